// File: logic/aor_pkg.sv
// Package with constants for the analog output ramp command block
package aor_pkg;
  // ==========================================================================
  // Command codes carried in the first command data word
  localparam logic [15:0] CMD_RAMP_OFF_1 = 16'h0040;
  localparam logic [15:0] CMD_RAMP_OFF_2 = 16'h0041;
  localparam logic [15:0] CMD_STEP_1 = 16'h0050;
  localparam logic [15:0] CMD_STEP_2 = 16'h0051;
  localparam logic [15:0] CMD_TIME_1 = 16'h0060;
  localparam logic [15:0] CMD_TIME_2 = 16'h0061;
  localparam logic [15:0] CMD_CLR_ERR = 16'h00c0;
  localparam logic [15:0] CMD_ALARM_MAX = 16'h0033;
  // ==========================================================================
  // Command block constants
  localparam logic [15:0] BLK_LENGTH = 16'h0004;
  localparam logic [15:0] BLK_CMD_NUMBER = 16'he201;
  localparam logic [15:0] BLK_DATA_BYTES = 16'h0006;
  // Word-mode and discrete memory type codes
  localparam logic [7:0] MT_REG = 8'h08;
  localparam logic [7:0] MT_AIN = 8'h0a;
  localparam logic [7:0] MT_AOUT = 8'h0c;
  localparam logic [7:0] MT_WORD = 8'hc4;
  localparam logic [7:0] MT_DIN_BYTE = 8'h10;
  localparam logic [7:0] MT_DIN_BIT = 8'h46;
  localparam logic [7:0] MT_DOUT_BYTE = 8'h12;
  localparam logic [7:0] MT_DOUT_BIT = 8'h48;
  localparam logic [7:0] MT_TMP_BYTE = 8'h14;
  localparam logic [7:0] MT_TMP_BIT = 8'h4a;
  localparam logic [7:0] MT_INT_BYTE = 8'h16;
  localparam logic [7:0] MT_INT_BIT = 8'h4c;
  localparam logic [7:0] MT_GLB_BYTE = 8'h38;
  localparam logic [7:0] MT_GLB_BIT = 8'h56;
  // ==========================================================================
  // Ramp limits and error codes
  localparam logic [15:0] RAMP_PARAM_MIN = 16'h0001;
  localparam logic [15:0] RAMP_PARAM_MAX = 16'h7d00;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CMD = 8'h01;
  localparam logic [7:0] ERR_BAD_PARAM = 8'h02;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 100000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  // Ramp modes
  typedef enum logic [1:0] {
    AOR_NORMAL = 2'b00,
    AOR_STEP = 2'b01,
    AOR_TIME = 2'b11
  } aor_mode_t;
endpackage

// File: logic/aor_chan.sv
// One output channel ramp engine
`timescale 1ns/1ps
module aor_chan
  import aor_pkg::*;
#(
  parameter logic signed [15:0] OUT_MIN = -16'sd32768,
  parameter logic signed [15:0] OUT_MAX = 16'sd32767
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic signed [15:0] i_target,
  input wire logic i_set_mode,
  input wire aor_mode_t i_mode,
  input wire logic [15:0] i_param,
  output logic signed [15:0] o_value,
  output aor_mode_t o_mode
);
  initial begin
    if (OUT_MIN >= OUT_MAX) $error("Output range is empty");
  end

  typedef struct packed {
    aor_mode_t mode;
    logic [15:0] param;
    logic signed [15:0] out;
    logic signed [15:0] start;
    logic signed [15:0] tgt;
    logic [15:0] elapsed;
  } aor_chan_st_t;

  aor_chan_st_t st_r;
  aor_chan_st_t st_nxt;
  logic signed [15:0] clamped;
  logic signed [17:0] diff;
  logic signed [17:0] stepped;
  logic signed [33:0] interp;
  logic [15:0] el_inc;

  // ==========================================================================
  // Clamp the new target before any ramp maths sees it
  always_comb begin
    if (i_target < OUT_MIN) begin
      clamped = OUT_MIN; // RL3
    end else if (i_target > OUT_MAX) begin
      clamped = OUT_MAX; // RL3
    end else begin
      clamped = i_target;
    end
  end

  // ==========================================================================
  // Ramp state update; mode lives only in flops, so power loss drops it
  always_comb begin
    st_nxt = st_r;
    el_inc = st_r.elapsed + 16'h0001;
    diff = 18'(st_r.tgt) - 18'(st_r.out);
    stepped = 18'sd0;
    interp = 34'sd0;
    if (st_r.mode == AOR_STEP && i_tick) begin
      // Stop on target instead of stepping past it
      if (diff > 18'($signed({1'b0, st_r.param}))) begin
        stepped = 18'(st_r.out) + 18'($signed({1'b0, st_r.param})); // RL5
      end else if (-diff > 18'($signed({1'b0, st_r.param}))) begin
        stepped = 18'(st_r.out) - 18'($signed({1'b0, st_r.param}));
      end else begin
        stepped = 18'(st_r.tgt); // RL28
      end
      st_nxt.out = stepped[15:0];
    end else if (st_r.mode == AOR_TIME && i_tick && st_r.out != st_r.tgt) begin
      if (el_inc >= st_r.param) begin
        st_nxt.out = st_r.tgt; // RL4
      end else begin
        interp = 34'(18'(st_r.tgt) - 18'(st_r.start)) * 34'($signed({1'b0, el_inc}));
        st_nxt.out = 16'(18'(st_r.start) + 18'(interp / 34'($signed({1'b0, st_r.param})))); // RL27
      end
      st_nxt.elapsed = el_inc;
    end
    // New target restarts the ramp from the present output
    if (clamped != st_r.tgt) begin
      st_nxt.tgt = clamped; // RL2
      // Start from the value this cycle leaves behind, so a tick in the same cycle is kept
      st_nxt.start = st_nxt.out;
      st_nxt.elapsed = 16'h0000;
      if (st_r.mode == AOR_NORMAL) begin
        st_nxt.out = clamped; // RL1
      end
    end
    if (i_set_mode) begin
      st_nxt.mode = i_mode; // RL6
      st_nxt.param = i_param; // RL9
      if (i_mode == AOR_NORMAL) begin
        st_nxt.out = clamped; // RL8
      end else if (i_mode == AOR_TIME) begin
        st_nxt.start = st_nxt.out; // RL10
        st_nxt.elapsed = 16'h0000;
      end
      st_nxt.tgt = clamped;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r <= '0; // RL7
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_value = st_r.out;
  assign o_mode = st_r.mode;

  chk_normal_follow: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL1
    (st_r.mode == AOR_NORMAL && !i_set_mode && clamped != st_r.tgt) |=> (st_r.out == $past(clamped)))
    else $error("Normal mode output did not follow target");
  chk_step_bound: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL28
    (st_r.mode == AOR_STEP && i_tick && !i_set_mode && clamped == st_r.tgt && st_r.out <= st_r.tgt)
    |=> (st_r.out <= st_r.tgt))
    else $error("Step ramp overshot target");
  chk_clamp_range: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL3
    ##1 (st_r.tgt >= OUT_MIN && st_r.tgt <= OUT_MAX))
    else $error("Stored target out of range");
endmodule

// File: logic/aor_top.sv
// Command interpreter and two-channel ramp control for the analog output module
`timescale 1ns/1ps
// Summary of operation
// (RL1) Normal mode: output jumps to new value
// (RL2) Ramp mode: target change starts a new ramp
// (RL3) Clamp out-of-range targets before ramping
// (RL4) Time ramp lasts 1 ms to 32 s
// (RL5) Step ramp moves once per millisecond
// (RL6) Mode kept until later command changes it
// (RL7) Reset drops all command settings
// (RL8) Ramp off jumps output to target
// (RL9) Step command takes over at once
// (RL10) Time command restarts from present output
// (RL11) Bad ramp command ignored, error code stored
// (RL12) Error code held until clear or reconfigure
// (RL13) Clear errors, alarm limits, ramp setup
// (RL14) Host builds ten-word command block
// (RL15) Host gives status and data locations
// (RL16) Host offsets are zero-based
// (RL17) Word memory type codes
// (RL18) Discrete memory type codes byte/bit
// (RL19) Host addresses rack and slot
// (RL20) Host sets task to zero
// (RL21) Host flags undeliverable command
// (RL22) Host issues request when enabled
// (RL23) Ramp off, step, time command codes
// (RL24) Step size 1 to 32000 counts
// (RL25) Code 00c0 clears error code
// (RL26) Bad commands never stop operation
// (RL27) Time ramp interpolates linearly each tick
// (RL28) Step ramp stops exactly on target
module aor_top
  import aor_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_reconfig,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_blk_len,
  input wire logic [15:0] i_cmd_number,
  input wire logic [15:0] i_cmd_byte_cnt,
  input wire logic [7:0] i_status_mem_type,
  input wire logic [7:0] i_data_mem_type,
  input wire logic [15:0] i_cmd_word,
  input wire logic [15:0] i_cmd_data,
  input wire logic signed [15:0] i_analog_output_word_1,
  input wire logic signed [15:0] i_analog_output_word_2,
  output logic o_cmd_done,
  output logic [15:0] o_cmd_status,
  output logic [7:0] o_error_code,
  output logic [2:0] o_alarm_sel,
  output logic o_alarm_write,
  output logic [15:0] o_alarm_value,
  output logic signed [15:0] o_out_1,
  output logic signed [15:0] o_out_2,
  output logic [1:0] o_mode_1,
  output logic [1:0] o_mode_2
);
  initial begin
    if (TICK_LEN < 1) $error("Tick length must be at least one cycle");
  end

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic done;
    logic [15:0] status;
    logic [7:0] err;
    logic [2:0] alarm_sel;
    logic alarm_write;
    logic [15:0] alarm_value;
    logic [1:0] set_mode;
    aor_mode_t mode;
    logic [15:0] param;
    logic signed [15:0] out_1;
    logic signed [15:0] out_2;
    logic [1:0] mode_1;
    logic [1:0] mode_2;
  } aor_top_st_t;

  aor_top_st_t st_r;
  aor_top_st_t st_nxt;
  logic signed [15:0] chan_out_1;
  logic signed [15:0] chan_out_2;
  aor_mode_t chan_mode_1;
  aor_mode_t chan_mode_2;
  logic blk_ok;
  logic mt_ok;
  logic param_ok;

  // ==========================================================================
  // Command block checks; memory types accepted per the code list
  always_comb begin
    blk_ok = i_cmd_blk_len == BLK_LENGTH && i_cmd_number == BLK_CMD_NUMBER && i_cmd_byte_cnt == BLK_DATA_BYTES;
    mt_ok = 1'b1;
    // RL17 RL18
    for (int k = 0; k < 2; k++) begin
      unique case (k == 0 ? i_status_mem_type : i_data_mem_type)
        MT_REG, MT_AIN, MT_AOUT, MT_WORD, MT_DIN_BYTE, MT_DIN_BIT, MT_DOUT_BYTE, MT_DOUT_BIT,
        MT_TMP_BYTE, MT_TMP_BIT, MT_INT_BYTE, MT_INT_BIT, MT_GLB_BYTE, MT_GLB_BIT: begin
        end
        default: begin
          mt_ok = 1'b0;
        end
      endcase
    end
    param_ok = i_cmd_data >= RAMP_PARAM_MIN && i_cmd_data <= RAMP_PARAM_MAX; // RL24
  end

  // ==========================================================================
  // Decode and execute one command per valid strobe; bad ones only set the code
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.alarm_write = 1'b0;
    st_nxt.set_mode = 2'b00;
    // One millisecond tick for both channels
    if (st_r.tick_cnt >= 32'(TICK_LEN - 1)) begin
      st_nxt.tick_cnt = 32'h0000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h0000_0001;
      st_nxt.tick = 1'b0;
    end
    if (i_reconfig) begin
      st_nxt.err = ERR_NONE; // RL12
    end
    if (i_cmd_valid) begin
      st_nxt.done = 1'b1;
      st_nxt.status = 16'h0001; // Never zero so the host sees completion
      if (!blk_ok || !mt_ok) begin
        st_nxt.err = ERR_BAD_CMD; // RL11
      end else if (i_cmd_word == CMD_CLR_ERR) begin
        st_nxt.err = ERR_NONE; // RL25
      end else if (i_cmd_word <= CMD_ALARM_MAX && i_cmd_word[3:0] < 4'h4) begin
        // Alarm limit change passed on to the input side
        st_nxt.alarm_sel = {i_cmd_word[5:4] == 2'b01 || i_cmd_word[5:4] == 2'b11, i_cmd_word[1:0]}; // RL13
        st_nxt.alarm_write = 1'b1;
        st_nxt.alarm_value = i_cmd_data;
      end else if (i_cmd_word == CMD_RAMP_OFF_1 || i_cmd_word == CMD_RAMP_OFF_2) begin
        st_nxt.set_mode = {i_cmd_word[0], ~i_cmd_word[0]}; // RL23
        st_nxt.mode = AOR_NORMAL;
      end else if (i_cmd_word == CMD_STEP_1 || i_cmd_word == CMD_STEP_2 ||
                   i_cmd_word == CMD_TIME_1 || i_cmd_word == CMD_TIME_2) begin
        if (param_ok) begin
          st_nxt.set_mode = {i_cmd_word[0], ~i_cmd_word[0]}; // RL23
          st_nxt.mode = i_cmd_word[5] ? AOR_TIME : AOR_STEP;
          st_nxt.param = i_cmd_data;
        end else begin
          st_nxt.err = ERR_BAD_PARAM; // RL11
        end
      end else begin
        st_nxt.err = ERR_BAD_CMD; // RL26
      end
    end
    st_nxt.out_1 = chan_out_1;
    st_nxt.out_2 = chan_out_2;
    st_nxt.mode_1 = chan_mode_1;
    st_nxt.mode_2 = chan_mode_2;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      st_r <= '0; // RL7
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Output channels
  aor_chan u_chan_1 (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_tick(st_r.tick),
    .i_target(i_analog_output_word_1),
    .i_set_mode(st_r.set_mode[0]),
    .i_mode(st_r.mode),
    .i_param(st_r.param),
    .o_value(chan_out_1),
    .o_mode(chan_mode_1)
  );
  aor_chan u_chan_2 (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_tick(st_r.tick),
    .i_target(i_analog_output_word_2),
    .i_set_mode(st_r.set_mode[1]),
    .i_mode(st_r.mode),
    .i_param(st_r.param),
    .o_value(chan_out_2),
    .o_mode(chan_mode_2)
  );

  assign o_cmd_done = st_r.done;
  assign o_cmd_status = st_r.status;
  assign o_error_code = st_r.err;
  assign o_alarm_sel = st_r.alarm_sel;
  assign o_alarm_write = st_r.alarm_write;
  assign o_alarm_value = st_r.alarm_value;
  assign o_out_1 = st_r.out_1;
  assign o_out_2 = st_r.out_2;
  assign o_mode_1 = st_r.mode_1;
  assign o_mode_2 = st_r.mode_2;

  // ==========================================================================
  // Checks
  chk_bad_param_err: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL11
    (i_cmd_valid && blk_ok && mt_ok && !param_ok && (i_cmd_word == CMD_STEP_1 || i_cmd_word == CMD_STEP_2 ||
     i_cmd_word == CMD_TIME_1 || i_cmd_word == CMD_TIME_2))
    |=> (st_r.err == ERR_BAD_PARAM && st_r.set_mode == 2'b00))
    else $error("Bad ramp parameter not reported");
  chk_err_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL12
    (!i_cmd_valid && !i_reconfig) |=> (st_r.err == $past(st_r.err)))
    else $error("Error code changed without cause");
  chk_clear_err: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL25
    (i_cmd_valid && blk_ok && mt_ok && i_cmd_word == CMD_CLR_ERR) |=> (st_r.err == ERR_NONE))
    else $error("Clear errors command ignored");
  chk_tick_period: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL5
    st_r.tick |=> !st_r.tick [*1])
    else $error("Tick fired twice in a row");
  chk_done_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RL26
    i_cmd_valid |=> (st_r.done && st_r.status != 16'h0000))
    else $error("Command completion missing");
endmodule

// File: tb/aor_host.sv
// Host model that builds command blocks and raises module command calls
`timescale 1ns/1ps
module aor_host
  import aor_pkg::*;
(
  input wire logic i_sys_clk,
  output logic o_cmd_valid,
  output logic [15:0] o_blk_len,
  output logic [15:0] o_number,
  output logic [15:0] o_byte_cnt,
  output logic [7:0] o_status_mt,
  output logic [7:0] o_data_mt,
  output logic [15:0] o_word,
  output logic [15:0] o_data,
  output logic o_delivery_fault
);
  // Module sits in rack 0, slot 2; the call's task word is always zero
  localparam logic [15:0] RACK_SLOT_WORD = 16'h0002;
  localparam logic [15:0] CALL_TASK = 16'h0000;
  // Status word at item 1, command data at item 101
  localparam logic [15:0] STATUS_ITEM = 16'h0001;
  localparam logic [15:0] DATA_ITEM = 16'h0065;
  logic [15:0] blk [10];
  // Quiet bus at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_blk_len = '0;
    o_number = '0;
    o_byte_cnt = '0;
    o_status_mt = '0;
    o_data_mt = '0;
    o_word = '0;
    o_data = '0;
    o_delivery_fault = 1'b0;
  end
  // ==========================================================
  // One request: held for the taking edge, then scrambled so
  // that stale fields can never pass for a fresh request
  task automatic send(input logic [15:0] w, input logic [15:0] d, input logic [15:0] len);
    // Ten-word block; words 1, 4 and 5 stay zero
    blk = '{default: 16'h0000};
    blk[0] = len;
    blk[2] = 16'(MT_REG);
    blk[3] = STATUS_ITEM - 16'h0001;
    blk[6] = BLK_CMD_NUMBER;
    blk[7] = BLK_DATA_BYTES;
    blk[8] = 16'(MT_WORD);
    blk[9] = DATA_ITEM - 16'h0001;
    @(posedge i_sys_clk);
    // A call with a nonzero task or no slot cannot be delivered
    o_delivery_fault <= CALL_TASK != 16'h0000 || RACK_SLOT_WORD[7:0] == 8'h00;
    o_cmd_valid <= CALL_TASK == 16'h0000 && RACK_SLOT_WORD[7:0] != 8'h00;
    o_blk_len <= blk[0];
    o_number <= blk[6];
    o_byte_cnt <= blk[7];
    o_status_mt <= blk[2][7:0];
    o_data_mt <= blk[8][7:0];
    o_word <= w;
    o_data <= d;
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b0;
    o_word <= ~w;
    o_data <= ~d;
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the output ramp command block
`timescale 1ns/1ps
module testbench;
  import aor_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reconfig = 1'b0;
  logic signed [15:0] tgt1 = '0;
  logic signed [15:0] tgt2 = '0;
  logic v, done, awr, dflt;
  logic [15:0] bl, num, bc, w, d, st, aval;
  logic [7:0] smt, dmt, err;
  logic [2:0] asel;
  logic signed [15:0] out1, out2;
  logic [1:0] m1, m2;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  aor_host host (.i_sys_clk(clk), .o_cmd_valid(v), .o_blk_len(bl), .o_number(num),
    .o_byte_cnt(bc), .o_status_mt(smt), .o_data_mt(dmt), .o_word(w), .o_data(d), .o_delivery_fault(dflt));
  // Short tick keeps ramps to tens of cycles
  aor_top #(.TICK_LEN(10)) dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_reconfig(reconfig),
    .i_cmd_valid(v), .i_cmd_blk_len(bl), .i_cmd_number(num), .i_cmd_byte_cnt(bc),
    .i_status_mem_type(smt), .i_data_mem_type(dmt), .i_cmd_word(w), .i_cmd_data(d),
    .i_analog_output_word_1(tgt1), .i_analog_output_word_2(tgt2), .o_cmd_done(done),
    .o_cmd_status(st), .o_error_code(err), .o_alarm_sel(asel), .o_alarm_write(awr),
    .o_alarm_value(aval), .o_out_1(out1), .o_out_2(out2), .o_mode_1(m1), .o_mode_2(m2));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // Settle just past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ==========================================================
  // Scenarios
  task automatic t_normal();
    chk(out1, 0);
    chk(m1, AOR_NORMAL);
    chk(err, ERR_NONE);
    @(posedge clk);
    tgt1 <= 16'sd100;
    cyc(3);
    chk(out1, 100);
    $display("end normal");
  endtask
  task automatic t_step();
    host.send(CMD_STEP_1, 16'h0007, BLK_LENGTH);
    // Completion pulse stands for the one cycle after the taking edge
    cyc(0);
    chk(done, 1);
    chk(st, 16'h0001);
    chk(dflt, 0);
    cyc(3);
    chk(m1, AOR_STEP);
    @(posedge clk);
    tgt1 <= 16'sd130;
    cyc(2);
    chk(out1 != 130, 1);
    // 30 counts at 7 per tick: the last step must stop short
    cyc(80);
    chk(out1, 130);
    $display("end step");
  endtask
  task automatic t_off();
    @(posedge clk);
    tgt1 <= 16'sd1000;
    cyc(20);
    chk(out1 != 1000, 1);
    host.send(CMD_RAMP_OFF_1, 16'h0000, BLK_LENGTH);
    cyc(3);
    chk(out1, 1000);
    chk(m1, AOR_NORMAL);
    $display("end off");
  endtask
  task automatic t_time();
    host.send(CMD_TIME_2, 16'h0004, BLK_LENGTH);
    cyc(3);
    chk(m2, AOR_TIME);
    @(posedge clk);
    tgt2 <= 16'sd400;
    cyc(25);
    chk(out2 % 100 == 0 && out2 > 0 && out2 < 400, 1);
    cyc(40);
    chk(out2, 400);
    $display("end time");
  endtask
  task automatic t_switch();
    @(posedge clk);
    tgt2 <= -16'sd400;
    cyc(5);
    host.send(CMD_STEP_2, 16'h0005, BLK_LENGTH);
    cyc(3);
    chk(m2, AOR_STEP);
    host.send(CMD_TIME_2, 16'h0002, BLK_LENGTH);
    cyc(3);
    chk(m2, AOR_TIME);
    cyc(40);
    chk(out2, -16'sd400);
    $display("end switch");
  endtask
  task automatic t_bad();
    host.send(CMD_STEP_2, 16'h0000, BLK_LENGTH);
    cyc(1);
    chk(err, ERR_BAD_PARAM);
    cyc(2);
    chk(m2, AOR_TIME);
    host.send(CMD_CLR_ERR, 16'h0000, BLK_LENGTH);
    cyc(1);
    chk(err, ERR_NONE);
    // Clear first so the over-range step must raise the code afresh
    host.send(CMD_STEP_2, 16'h7d01, BLK_LENGTH);
    cyc(1);
    chk(err, ERR_BAD_PARAM);
    host.send(CMD_STEP_2, 16'h0005, 16'h0005);
    cyc(1);
    chk(err, ERR_BAD_CMD);
    // A later good command runs but leaves the error standing
    host.send(CMD_TIME_1, 16'h0005, BLK_LENGTH);
    cyc(3);
    chk(err, ERR_BAD_CMD);
    chk(m1, AOR_TIME);
    @(posedge clk);
    reconfig <= 1'b1;
    @(posedge clk);
    reconfig <= 1'b0;
    cyc(2);
    chk(err, ERR_NONE);
    chk(m1, AOR_TIME);
    host.send(CMD_STEP_1, RAMP_PARAM_MAX, BLK_LENGTH);
    cyc(3);
    chk(err, ERR_NONE);
    chk(m1, AOR_STEP);
    $display("end bad");
  endtask
  task automatic t_alarm();
    host.send(16'h0012, 16'h04d2, BLK_LENGTH);
    cyc(0);
    chk(awr, 1);
    chk(asel, 3'b110);
    chk(aval, 16'h04d2);
    cyc(1);
    chk(awr, 0);
    host.send(16'h0001, 16'hfff0, BLK_LENGTH);
    cyc(0);
    chk(awr, 1);
    chk(asel, 3'b001);
    chk(aval, 16'hfff0);
    // Input index of four or above is refused and writes no limit
    host.send(16'h0014, 16'h0001, BLK_LENGTH);
    cyc(0);
    chk(awr, 0);
    cyc(1);
    chk(err, ERR_BAD_CMD);
    chk(asel, 3'b001);
    host.send(CMD_CLR_ERR, 16'h0000, BLK_LENGTH);
    cyc(1);
    chk(err, ERR_NONE);
    host.send(16'h0070, 16'h0001, BLK_LENGTH);
    cyc(1);
    chk(err, ERR_BAD_CMD);
    $display("end alarm");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    t_normal();
    t_step();
    t_off();
    t_time();
    t_switch();
    t_bad();
    t_alarm();
    close_out();
  end
endmodule
